//--- hdl/timer16_mode_sequencer.sv
/*
  16-bit timer mode sequencer: normal, clear-on-match and fast pwm counting,
  two compare channels, flags and waveform outputs, axi4-lite registers.
  assumes one clock aclk, synchronous active-low aresetn, well-behaved master.
*/
`timescale 1ns/1ps
`default_nettype none
module timer16_mode_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       wave_pin,
  output logic [1:0]       wave_pin_oe
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] count_value;
    logic [15:0] compare_a_buf;
    logic [15:0] compare_a_value;
    logic [15:0] compare_b_value;
    logic [15:0] capture_top_value;
    logic        overflow_flag;
    logic        compare_a_flag;
    logic        compare_b_flag;
    logic        capture_flag;
    logic [1:0]  match_pend;
    logic        block_match;
    logic [1:0]  wave_out;
    logic [1:0]  wave_pin;
    logic [1:0]  wave_pin_oe;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } seq_state_t;

  seq_state_t st_r;
  seq_state_t st_nxt;

  tick_if tk ();

  timer16_prescaler u_pre (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .tk      (tk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoded configuration
  logic [3:0]  waveform_mode_field;
  logic [1:0]  output_action_field [2];
  logic [1:0]  pin_direction_bit;
  logic        fast_pwm;
  logic        clear_on_match_mode;
  logic        fixed_top;
  logic [15:0] top_val;
  logic [15:0] res_mask;
  logic        top_is_cmp_a;
  logic        top_is_cap;
  logic [15:0] cmp_now [2];

  assign waveform_mode_field    = st_r.ctrl[timer16_pkg::mode_lsb +: 4];
  assign output_action_field[0] = st_r.ctrl[timer16_pkg::act_a_lsb +: 2];
  assign output_action_field[1] = st_r.ctrl[timer16_pkg::act_b_lsb +: 2];
  assign pin_direction_bit      = {st_r.ctrl[timer16_pkg::dir_b_bit], st_r.ctrl[timer16_pkg::dir_a_bit]};
  assign tk.sel                 = st_r.ctrl[timer16_pkg::presc_lsb +: 3];
  assign cmp_now[0]             = st_r.compare_a_value;
  assign cmp_now[1]             = st_r.compare_b_value;

  // mode decode looks only at the waveform mode field
  always_comb begin
    fast_pwm     = 1'b0;
    clear_on_match_mode          = 1'b0;
    fixed_top    = 1'b0;
    top_val      = timer16_pkg::count_max;
    res_mask     = timer16_pkg::count_max;
    top_is_cmp_a = 1'b0;
    top_is_cap   = 1'b0;
    case (waveform_mode_field)
      timer16_pkg::mode_ctc_cmp: begin
        clear_on_match_mode = 1'b1; top_val = st_r.compare_a_value; top_is_cmp_a = 1'b1;
      end
      timer16_pkg::mode_ctc_cap: begin
        clear_on_match_mode = 1'b1; top_val = st_r.capture_top_value; top_is_cap = 1'b1;
      end
      timer16_pkg::mode_fast8: begin
        fast_pwm = 1'b1; fixed_top = 1'b1; top_val = timer16_pkg::top_fixed8; res_mask = timer16_pkg::top_fixed8;
      end
      timer16_pkg::mode_fast9: begin
        fast_pwm = 1'b1; fixed_top = 1'b1; top_val = timer16_pkg::top_fixed9; res_mask = timer16_pkg::top_fixed9;
      end
      timer16_pkg::mode_fast10: begin
        fast_pwm = 1'b1; fixed_top = 1'b1; top_val = timer16_pkg::top_fixed10; res_mask = timer16_pkg::top_fixed10;
      end
      timer16_pkg::mode_fast_cap: begin
        fast_pwm = 1'b1; top_val = st_r.capture_top_value; top_is_cap = 1'b1;
      end
      timer16_pkg::mode_fast_cmp: begin
        fast_pwm = 1'b1; top_val = st_r.compare_a_value; top_is_cmp_a = 1'b1;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read and write handling helpers
  logic        wr_go;
  logic        rd_go;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic [1:0]  rd_resp;
  logic        wr_hit;

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign wr_go         = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  // byte-lane merge of the pending write into the addressed register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // read mux; unmapped addresses answer slverr
  always_comb begin
    rd_val  = 32'h0000_0000;
    rd_resp = timer16_pkg::resp_okay;
    if (s_axi_araddr == timer16_pkg::ctrl_off) begin
      rd_val = st_r.ctrl;
    end else if (s_axi_araddr == timer16_pkg::count_off) begin
      rd_val = {16'h0000, st_r.count_value};
    end else if (s_axi_araddr == timer16_pkg::cmp_a_off) begin
      rd_val = {16'h0000, fast_pwm ? st_r.compare_a_buf : st_r.compare_a_value};
    end else if (s_axi_araddr == timer16_pkg::cmp_b_off) begin
      rd_val = {16'h0000, st_r.compare_b_value};
    end else if (s_axi_araddr == timer16_pkg::cap_top_off) begin
      rd_val = {16'h0000, st_r.capture_top_value};
    end else if (s_axi_araddr == timer16_pkg::flags_off) begin
      rd_val = {28'h0000000, st_r.capture_flag, st_r.compare_b_flag, st_r.compare_a_flag, st_r.overflow_flag};
    end else if (s_axi_araddr == timer16_pkg::status_off) begin
      rd_val = {12'h000, st_r.compare_a_value, st_r.wave_pin, st_r.wave_out};
    end else begin
      rd_resp = timer16_pkg::resp_slverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus, counter, compare, flags, outputs
  logic        tick;
  logic        at_top;
  logic        wrap;
  logic        cnt_wr;
  logic [1:0]  match;
  logic [15:0] next_cnt;
  logic [15:0] wr16;

  assign tick = tk.tick;

  always_comb begin
    st_nxt  = st_r;
    cnt_wr  = 1'b0;
    wr_hit  = 1'b1;
    wr_val  = 32'h0000_0000;
    wr16    = 16'h0000;
    match   = 2'b00;

    // channel capture in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_resp;
    end

    // write-one clears go first, so a hardware set in the same cycle wins
    if (wr_go && st_r.awaddr == timer16_pkg::flags_off && st_r.wstrb[0]) begin
      if (st_r.wdata[timer16_pkg::ovf_bit])  st_nxt.overflow_flag  = 1'b0;
      if (st_r.wdata[timer16_pkg::cmpa_bit]) st_nxt.compare_a_flag = 1'b0;
      if (st_r.wdata[timer16_pkg::cmpb_bit]) st_nxt.compare_b_flag = 1'b0;
      if (st_r.wdata[timer16_pkg::cap_bit])  st_nxt.capture_flag   = 1'b0;
    end

    // timer stepping on the prescaled tick
    at_top   = st_r.count_value == top_val;
    wrap     = st_r.count_value == timer16_pkg::count_max;
    next_cnt = st_r.count_value + 16'h0001; // wraps through max
    if ((clear_on_match_mode || fast_pwm) && at_top) begin
      next_cnt = 16'h0000;
    end

    if (tick) begin
      st_nxt.count_value = next_cnt;
      // compare detection; a count write blocks it for one tick
      for (int c = 0; c < 2; c++) begin
        match[c] = !st_r.block_match && (st_r.count_value == cmp_now[c]);
      end
      st_nxt.block_match = 1'b0;
      // flags set one tick after the match, except compare A while it sets top
      if (st_r.match_pend[0] && !(top_is_cmp_a && (clear_on_match_mode || fast_pwm))) begin
        st_nxt.compare_a_flag = 1'b1;
      end
      if (st_r.match_pend[1]) begin
        st_nxt.compare_b_flag = 1'b1;
      end
      st_nxt.match_pend = match;
      if (!fast_pwm && wrap) begin
        st_nxt.overflow_flag = 1'b1; // max to zero, also when top is max
      end
      if ((clear_on_match_mode || fast_pwm) && at_top && !st_r.block_match) begin
        if (top_is_cmp_a) st_nxt.compare_a_flag = 1'b1;
        if (top_is_cap)   st_nxt.capture_flag   = 1'b1;
      end
      if (fast_pwm && at_top) begin
        st_nxt.overflow_flag   = 1'b1;
        st_nxt.compare_a_value = st_r.compare_a_buf;
      end
      // waveform actions per channel
      for (int c = 0; c < 2; c++) begin
        if (fast_pwm) begin
          if (match[c]) begin
            case (output_action_field[c])
              timer16_pkg::act_clear: st_nxt.wave_out[c] = 1'b0;
              timer16_pkg::act_set:   st_nxt.wave_out[c] = 1'b1;
              timer16_pkg::act_toggle: begin
                if (c == 0 && waveform_mode_field == timer16_pkg::mode_fast_cmp) begin
                  st_nxt.wave_out[c] = !st_r.wave_out[c];
                end
              end
              default: begin
              end
            endcase
          end
          // bottom action; a match at top leaves constant level
          if (at_top && !(match[c] && cmp_now[c] == top_val)) begin
            if (output_action_field[c] == timer16_pkg::act_clear) st_nxt.wave_out[c] = 1'b1;
            if (output_action_field[c] == timer16_pkg::act_set)   st_nxt.wave_out[c] = 1'b0;
          end
        end else if (match[c]) begin
          case (output_action_field[c])
            timer16_pkg::act_toggle: st_nxt.wave_out[c] = !st_r.wave_out[c];
            timer16_pkg::act_clear:  st_nxt.wave_out[c] = 1'b0;
            timer16_pkg::act_set:    st_nxt.wave_out[c] = 1'b1;
            default: begin
            end
          endcase
        end
      end
    end

    // pin override only while direction selects output
    for (int c = 0; c < 2; c++) begin
      st_nxt.wave_pin_oe[c] = pin_direction_bit[c] && (output_action_field[c] != timer16_pkg::act_none);
      st_nxt.wave_pin[c]    = st_nxt.wave_pin_oe[c] ? st_nxt.wave_out[c] : 1'b0;
    end

    // register write commits after both address and data are in
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (st_r.awaddr == timer16_pkg::ctrl_off) begin
        st_nxt.ctrl = merge(st_r.ctrl, st_r.wdata, st_r.wstrb) & 32'h0000_37ff;
      end else if (st_r.awaddr == timer16_pkg::count_off) begin
        wr_val = merge({16'h0000, st_r.count_value}, st_r.wdata, st_r.wstrb);
        st_nxt.count_value = wr_val[15:0]; // write wins over stepping
        cnt_wr = 1'b1;
      end else if (st_r.awaddr == timer16_pkg::cmp_a_off) begin
        wr_val = merge({16'h0000, fast_pwm ? st_r.compare_a_buf : st_r.compare_a_value}, st_r.wdata, st_r.wstrb);
        wr16 = wr_val[15:0] & (fixed_top ? res_mask : timer16_pkg::count_max);
        if (fast_pwm) begin
          st_nxt.compare_a_buf = wr16;
        end else begin
          st_nxt.compare_a_value = wr16; // unbuffered
          st_nxt.compare_a_buf   = wr16;
        end
      end else if (st_r.awaddr == timer16_pkg::cmp_b_off) begin
        wr_val = merge({16'h0000, st_r.compare_b_value}, st_r.wdata, st_r.wstrb);
        st_nxt.compare_b_value = wr_val[15:0] & (fixed_top ? res_mask : timer16_pkg::count_max);
      end else if (st_r.awaddr == timer16_pkg::cap_top_off) begin
        wr_val = merge({16'h0000, st_r.capture_top_value}, st_r.wdata, st_r.wstrb);
        st_nxt.capture_top_value = wr_val[15:0]; // no buffer
      end else if (st_r.awaddr != timer16_pkg::flags_off && st_r.awaddr != timer16_pkg::status_off) begin
        wr_hit = 1'b0; // flags were cleared ahead of the timer step
      end
      st_nxt.bresp = wr_hit ? timer16_pkg::resp_okay : timer16_pkg::resp_slverr;
    end
    if (cnt_wr) begin
      st_nxt.block_match = 1'b1; // holds until the next tick
      st_nxt.match_pend  = 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.ctrl <= timer16_pkg::ctrl_rst;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;
  assign wave_pin     = st_r.wave_pin;
  assign wave_pin_oe  = st_r.wave_pin_oe;
endmodule : timer16_mode_sequencer
`default_nettype wire

//--- common/timer16_pkg.sv
/*
  package for the 16-bit timer mode sequencer: register offsets, field
  positions, reset values, mode codes and prescaler constants.
  assumes an axi4-lite master with 32-bit data, word-aligned accesses.
*/
package timer16_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ctrl_off     = 8'h00; // mode, actions, prescale, dirs
  localparam logic [7:0] count_off    = 8'h04;
  localparam logic [7:0] cmp_a_off    = 8'h08;
  localparam logic [7:0] cmp_b_off    = 8'h0c;
  localparam logic [7:0] cap_top_off  = 8'h10;
  localparam logic [7:0] flags_off    = 8'h14; // write one to clear
  localparam logic [7:0] status_off   = 8'h18; // outputs, pins, active cmp a

  ////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int mode_lsb    = 0;  // 4 bits
  localparam int act_a_lsb   = 4;  // 2 bits
  localparam int act_b_lsb   = 6;  // 2 bits
  localparam int presc_lsb   = 8;  // 3 bits
  localparam int dir_a_bit   = 12;
  localparam int dir_b_bit   = 13;

  // flag bit positions
  localparam int ovf_bit   = 0;
  localparam int cmpa_bit  = 1;
  localparam int cmpb_bit  = 2;
  localparam int cap_bit   = 3;

  localparam logic [31:0] ctrl_rst = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // waveform modes and output actions
  localparam logic [3:0] mode_normal   = 4'h0;
  localparam logic [3:0] mode_ctc_cmp  = 4'h4;
  localparam logic [3:0] mode_fast8    = 4'h5;
  localparam logic [3:0] mode_fast9    = 4'h6;
  localparam logic [3:0] mode_fast10   = 4'h7;
  localparam logic [3:0] mode_ctc_cap  = 4'hc;
  localparam logic [3:0] mode_fast_cap = 4'he;
  localparam logic [3:0] mode_fast_cmp = 4'hf;

  localparam logic [1:0] act_none   = 2'h0;
  localparam logic [1:0] act_toggle = 2'h1;
  localparam logic [1:0] act_clear  = 2'h2;
  localparam logic [1:0] act_set    = 2'h3;

  localparam logic [15:0] top_fixed8  = 16'h00ff;
  localparam logic [15:0] top_fixed9  = 16'h01ff;
  localparam logic [15:0] top_fixed10 = 16'h03ff;
  localparam logic [15:0] count_max   = 16'hffff;

  // prescaler selects: 0 stopped, 1..5 divide by 1,8,64,256,1024
  localparam logic [2:0] presc_stop = 3'h0;
  localparam logic [2:0] presc_1    = 3'h1;
  localparam logic [2:0] presc_8    = 3'h2;
  localparam logic [2:0] presc_64   = 3'h3;
  localparam logic [2:0] presc_256  = 3'h4;
  localparam logic [2:0] presc_1024 = 3'h5;
  localparam logic [9:0] div8_mask    = 10'h007;
  localparam logic [9:0] div64_mask   = 10'h03f;
  localparam logic [9:0] div256_mask  = 10'h0ff;
  localparam logic [9:0] div1024_mask = 10'h3ff;

  // axi responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

endpackage : timer16_pkg

//--- common/tick_if.sv
/*
  interface carrying the prescaler selection and tick between the top and
  its prescaler. assumes both ends share aclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic [2:0] sel;
  logic       tick;
  modport ctrl (output sel, input tick);
  modport gen  (input sel, output tick);
endinterface : tick_if
`default_nettype wire

//--- hdl/timer16_prescaler.sv
/*
  prescaler: free 10-bit divider giving a one-cycle tick per selected factor.
  assumes synchronous active-low reset and a shared clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module timer16_prescaler (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clk_en,
  tick_if.gen       tk
);
  typedef struct packed {
    logic [9:0] div;
  } pre_state_t;

  pre_state_t st_r;
  pre_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // divider runs always; tick is a mask test, so the phase is shared
  always_comb begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + 10'h001;
  end

  always_comb begin
    case (tk.sel)
      timer16_pkg::presc_1:    tk.tick = 1'b1;
      timer16_pkg::presc_8:    tk.tick = (st_r.div & timer16_pkg::div8_mask) == 10'h000;
      timer16_pkg::presc_64:   tk.tick = (st_r.div & timer16_pkg::div64_mask) == 10'h000;
      timer16_pkg::presc_256:  tk.tick = (st_r.div & timer16_pkg::div256_mask) == 10'h000;
      timer16_pkg::presc_1024: tk.tick = (st_r.div & timer16_pkg::div1024_mask) == 10'h000;
      default:                 tk.tick = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end
endmodule : timer16_prescaler
`default_nettype wire

//--- tb/timer16_seq_chk.sv
/* assertions on the timer16_mode_sequencer ports: bus handshakes, pin gating.
   assumes one clock aclk, synchronous active-low aresetn, bound to the top. */
`timescale 1ns/1ps
`default_nettype none
module timer16_seq_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  wave_pin,
  input wire logic [1:0]  wave_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves taken, then two enabled edges for the commit
  sequence both_taken;
    clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 clk_en ##1 clk_en;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_write_answer: assert property (both_taken |-> ##[0:1] s_axi_bvalid)
    else $error("write response late");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_bresp_once: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_pin_gated: assert property ((wave_pin & ~wave_pin_oe) == 2'h0)
    else $error("pin driven while disabled");
  // reset itself is the antecedent, so no disable here
  chk_reset_clears: assert property (disable iff (1'b0) !aresetn && clk_en |=>
    wave_pin == 2'h0 && wave_pin_oe == 2'h0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
endmodule : timer16_seq_chk
bind timer16_mode_sequencer timer16_seq_chk chk (.*);
`default_nettype wire

//--- tb/test_timer16_mode_sequencer.sv
/* self-checking bench for timer16_mode_sequencer over axi4-lite.
   assumes package compiled first; clk_en and wstrb held constant. */
`timescale 1ns/1ps
`default_nettype none
module test_timer16_mode_sequencer;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wave_pin, wave_pin_oe, rrsp;
  logic [31:0] s_axi_rdata, rdat;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          h2, h3;
  int          dv [5] = '{1, 8, 64, 256, 1024};
  // design, ports matched by name
  timer16_mode_sequencer dut (.*);
  // 25 ns period
  always #12.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // a spent wait bound ends the run
  task automatic lim(input bit ok);
    if (!ok) begin
      n_fail++;
      results();
    end
  endtask : lim
  // write one word, each channel held until its ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit dn = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int i = 0; i < 40 && !dn; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) {dn, rrsp} = {1'b1, s_axi_bresp};
    end
    s_axi_bready <= 1'b0;
    lim(dn);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bit dn = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int i = 0; i < 40 && !dn; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) {dn, rdat, rrsp} = {1'b1, s_axi_rdata, s_axi_rresp};
    end
    s_axi_rready <= 1'b0;
    lim(dn);
  endtask : rd
  // control word: channel A pin enabled, channel B idle
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] a, input logic [2:0] p);
    return {18'h0, 2'h1, 1'b0, p, 2'h0, a, m};
  endfunction : ctl
  // length of the next whole phase at level l on pin A
  task automatic span(input logic l, output int n);
    int i;
    for (i = 0; i < 20000 && wave_pin[0] === l; i++) @(posedge aclk);
    for (i = i; i < 20000 && wave_pin[0] !== l; i++) @(posedge aclk);
    for (n = 0; n < 20000 && wave_pin[0] === l; n++) @(posedge aclk);
    lim(i + n < 20000);
  endtask : span
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(timer16_pkg::ctrl_off);
    chk("ctrl reset", timer16_pkg::ctrl_rst, rdat);
    rd(timer16_pkg::status_off);
    chk("status reset", 32'h0, rdat);
    rd(8'h1c);
    chk("unmapped read", {30'h0, timer16_pkg::resp_slverr}, {rdat[31:2], rrsp});
    wr(8'h1c, 32'h1);
    chk("unmapped write", {30'h0, timer16_pkg::resp_slverr}, {30'h0, rrsp});
  endtask : t_regs
  // burst of ticks from count c, then masked flags judged
  task automatic trial(input logic [3:0] m, input logic [1:0] a, input logic [15:0] c, input logic [3:0] k,
                       input logic [3:0] e);
    wr(timer16_pkg::ctrl_off, ctl(m, a, timer16_pkg::presc_stop));
    wr(timer16_pkg::count_off, {16'h0, c});
    wr(timer16_pkg::flags_off, 32'hf);
    wr(timer16_pkg::ctrl_off, ctl(m, a, timer16_pkg::presc_1));
    repeat (40) @(posedge aclk);
    wr(timer16_pkg::ctrl_off, ctl(m, a, timer16_pkg::presc_stop));
    rd(timer16_pkg::flags_off);
    chk("flags", {28'h0, e}, {28'h0, rdat[3:0] & k});
  endtask : trial
  task automatic t_flags;
    wr(timer16_pkg::cmp_a_off, 32'h3);
    wr(timer16_pkg::cap_top_off, 32'h5);
    trial(timer16_pkg::mode_normal, 2'h0, 16'hffe8, 4'h7, 4'h7);
    rd(timer16_pkg::count_off);
    chk("count wrapped", 32'h1, {31'h0, rdat > 32'h4 && rdat < 32'h40});
    trial(timer16_pkg::mode_normal, 2'h0, 16'h0, 4'h4, 4'h0);
    trial(timer16_pkg::mode_ctc_cmp, 2'h0, 16'h0, 4'hb, 4'h2);
    trial(timer16_pkg::mode_ctc_cmp, 2'h3, 16'h0, 4'hb, 4'h2);
    trial(timer16_pkg::mode_ctc_cmp, 2'h0, 16'hffe8, 4'h3, 4'h3);
    trial(timer16_pkg::mode_ctc_cap, 2'h0, 16'h0, 4'h9, 4'h8);
    trial(timer16_pkg::mode_ctc_cap, 2'h0, 16'h10, 4'h9, 4'h0);
    trial(timer16_pkg::mode_fast_cap, 2'h0, 16'h0, 4'h9, 4'h9);
    trial(timer16_pkg::mode_fast_cap, 2'h0, 16'h10, 4'h9, 4'h0);
    trial(timer16_pkg::mode_fast_cmp, 2'h0, 16'h0, 4'hb, 4'h3);
  endtask : t_flags
  // toggle on match at every prescale factor, then pin released
  task automatic t_wave;
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_ctc_cmp, timer16_pkg::act_toggle, timer16_pkg::presc_stop));
    wr(timer16_pkg::count_off, 32'h0);
    wr(timer16_pkg::cmp_a_off, 32'h3);
    for (int p = 1; p <= 5; p++) begin
      wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_ctc_cmp, timer16_pkg::act_toggle, 3'(p)));
      span(1'b1, h2);
      chk("toggle phase", 32'(4 * dv[p - 1]), 32'(h2));
    end
    chk("pin enable", 32'h1, {31'h0, wave_pin_oe[0]});
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_ctc_cmp, timer16_pkg::act_toggle, 3'h1) & 32'hffffefff);
    repeat (3) @(posedge aclk);
    chk("pin off", 32'h0, {30'h0, wave_pin_oe[0], wave_pin[0]});
  endtask : t_wave
  task automatic t_pwm;
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast8, timer16_pkg::act_clear, timer16_pkg::presc_stop));
    wr(timer16_pkg::cmp_a_off, 32'h1234);
    rd(timer16_pkg::cmp_a_off);
    chk("masked compare", 32'h34, rdat);
    wr(timer16_pkg::cmp_a_off, 32'h40);
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast8, timer16_pkg::act_clear, timer16_pkg::presc_1));
    span(1'b1, h2);
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast8, timer16_pkg::act_set, timer16_pkg::presc_1));
    span(1'b1, h3);
    chk("pwm period", 32'd256, 32'(h2 + h3));
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast_cmp, timer16_pkg::act_toggle, timer16_pkg::presc_stop));
    wr(timer16_pkg::count_off, 32'h0);
    wr(timer16_pkg::cmp_a_off, 32'h9);
    rd(timer16_pkg::status_off);
    chk("active compare", 32'h40, {16'h0, rdat[19:4]});
    rd(timer16_pkg::cmp_a_off);
    chk("compare buffer", 32'h9, rdat);
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast_cmp, timer16_pkg::act_toggle, timer16_pkg::presc_1));
    span(1'b1, h2);
    span(1'b1, h2);
    chk("square phase", 32'd10, 32'(h2));
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast8, timer16_pkg::act_clear, timer16_pkg::presc_stop));
    wr(timer16_pkg::cmp_a_off, 32'h0);
    wr(timer16_pkg::ctrl_off, ctl(timer16_pkg::mode_fast8, timer16_pkg::act_clear, timer16_pkg::presc_1));
    span(1'b1, h2);
    chk("spike width", 32'h1, 32'(h2));
  endtask : t_pwm
  ////////////////////////////////////////////////////////////////
  // reset six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_flags();
    t_wave();
    t_pwm();
    results();
  end
endmodule : test_timer16_mode_sequencer
`default_nettype wire
